// [rtl/uei_rx_irq.sv]
// Serial receiver with error flags, interrupt and wake-up logic
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Noise sets flag with data flag, word kept
// - Noise alone never requests interrupt
// - Noise cleared by status then data read
// - Low stop bit sets framing error
// - Framing error stored with word, reset clears
// - Parity mismatch flagged only when checking on
// - Six sources pulse interrupt line low
// - Separate transmit enables, shared receiver enable
// - Service needs global, uart enable, stack room
// - Address detect interrupts without status flag
// - Clock-off RX falling edge interrupts, no flag
// - Status flags read-only, cleared by uart
// - Address mode: interrupt only when top bit
// - No address mode: interrupt every word
// - Clock stopped pauses reception in place
// - Idle or sleep leaves registers unchanged
// - Wake armed only with wake, port, receiver and receive irq enables set
// - RX data ignored during wake recovery
// - Wake interrupt needs enables, after recovery
// - Two-word receive queue, third overruns
// - Overrun requests interrupt with receive irq enable
module uei_rx_irq #(
  parameter int RECOV = uei_pkg::RECOV_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial line and power state
  input wire logic rx,
  input wire logic serial_port_clock_on,
  input wire logic power_down,
  // System side
  input wire uei_pkg::uei_sys_in_type sys_i,
  output logic wake_req,
  output logic uart_irq_n,
  output logic uart_req,
  output logic irq_service
);
  uei_pkg::uei_state_type s, n;
  logic req_new, acc, rd_acc, wr_acc, tick, run, maj, noisy;
  logic pd_in, fall, push, top, rxf, nine, ev;
  logic [3:0] last;

  assign wb_ack_o = s.ack;
  assign wb_dat_o = {24'h000000, s.rdat};
  assign wake_req = s.wake;
  assign uart_irq_n = s.irq_n;
  assign uart_req = s.req;
  assign irq_service = s.serv;

  always_comb begin
    n = s;
    req_new = wb_cyc_i & wb_stb_i & ~s.ack;
    acc = wb_cyc_i & wb_stb_i & s.ack;
    rd_acc = acc & ~wb_we_i;
    wr_acc = acc & wb_we_i & wb_sel_i[0];
    nine = s.c1[uei_pkg::C1_NINE];
    last = nine ? 4'h8 : 4'h7;
    rxf = (s.cnt != 2'h0);
    pd_in = power_down & ~serial_port_clock_on;
    fall = s.rx_prev & ~rx;
    push = 1'b0;
    ev = 1'b0;
    maj = (s.smp[0] & s.smp[1]) | (s.smp[0] & s.smp[2]) | (s.smp[1] & s.smp[2]);
    noisy = ~(&s.smp) & (|s.smp);
    top = nine ? s.shf[8] : s.shf[7];
    n.ack = req_new;
    n.wake = 1'b0;
    n.irq_n = 1'b1;
    n.rx_prev = rx;
    n.txe_prev = sys_i.tx_empty;
    n.txi_prev = sys_i.tx_idle;
    n.pd_prev = pd_in;
    // Register read data latched when the request is first seen
    if (req_new) begin
      n.pop_ok = 1'b0;
      case (wb_adr_i)
        uei_pkg::OFS_STATUS: begin
          n.rdat = {sys_i.tx_empty, sys_i.tx_idle, rxf, s.rs == uei_pkg::RX_IDLE,
                    s.f_oe, s.f_nf, s.f_fe, s.f_pe};
        end
        uei_pkg::OFS_CTRL1: begin
          n.rdat = {s.c1[7:1], s.fd[s.hd][8]};
        end
        uei_pkg::OFS_CTRL2: begin
          n.rdat = s.c2;
        end
        uei_pkg::OFS_DATA: begin
          n.rdat = s.fd[s.hd][7:0];
          n.pop_ok = rxf;
        end
        uei_pkg::OFS_BAUD: begin
          n.rdat = s.baud;
        end
        uei_pkg::OFS_INTC: begin
          n.rdat = {6'h00, s.ic};
        end
        default: begin
          n.rdat = 8'h00;
        end
      endcase
    end
    // Writes take effect at the acknowledging edge; status is not writable
    if (wr_acc) begin
      case (wb_adr_i)
        uei_pkg::OFS_CTRL1: n.c1 = {wb_dat_i[7:1], 1'b0};
        uei_pkg::OFS_CTRL2: n.c2 = wb_dat_i[7:0];
        uei_pkg::OFS_BAUD: n.baud = wb_dat_i[7:0];
        uei_pkg::OFS_INTC: n.ic = wb_dat_i[1:0];
        default: n.c1 = s.c1;
      endcase
    end
    // Status read then data read clears error flags and pops
    if (rd_acc && wb_adr_i == uei_pkg::OFS_STATUS) begin
      n.seen = 1'b1;
    end
    if (rd_acc && wb_adr_i == uei_pkg::OFS_DATA) begin
      if (s.seen) begin
        n.f_nf = 1'b0;
        n.f_fe = 1'b0;
        n.f_pe = 1'b0;
        n.f_oe = 1'b0;
      end
      n.seen = 1'b0;
      if (s.pop_ok) begin
        n.hd = ~s.hd;
        n.cnt = s.cnt - 2'h1;
      end
    end
    // Receiver runs only while its clock is on and it is enabled
    run = s.c1[uei_pkg::C1_PORT] & s.c2[uei_pkg::C2_RXON] & (s.rec == 8'h00);
    tick = (s.bcnt == s.baud);
    if (!serial_port_clock_on) begin
      n.rs = s.rs;
    end else if (!run) begin
      n.rs = uei_pkg::RX_IDLE;
      n.bcnt = 8'h00;
    end else begin
      n.bcnt = tick ? 8'h00 : s.bcnt + 8'h01;
      if (s.rs == uei_pkg::RX_IDLE) begin
        if (fall) begin
          n.rs = uei_pkg::RX_START;
          n.ovs = 4'h0;
          n.bcnt = 8'h00;
          n.shf = 9'h000;
          n.bitn = 4'h0;
          n.nz = 1'b0;
          n.pe = 1'b0;
          n.fe = 1'b0;
        end
      end else if (tick) begin
        n.ovs = s.ovs + 4'h1;
        if (s.ovs == uei_pkg::SMP_A) n.smp[0] = rx;
        if (s.ovs == uei_pkg::SMP_B) n.smp[1] = rx;
        if (s.ovs == uei_pkg::SMP_C) n.smp[2] = rx;
        if (s.ovs == uei_pkg::SMP_END) begin
          n.nz = s.nz | noisy;
          case (s.rs)
            uei_pkg::RX_START: begin
              n.rs = maj ? uei_pkg::RX_IDLE : uei_pkg::RX_DATA;
            end
            uei_pkg::RX_DATA: begin
              n.shf[s.bitn] = maj;
              n.bitn = s.bitn + 4'h1;
              if (s.bitn == last) begin
                n.rs = s.c1[uei_pkg::C1_PAR] ? uei_pkg::RX_PAR : uei_pkg::RX_STOP1;
              end
            end
            uei_pkg::RX_PAR: begin
              n.pe = (^s.shf) ^ maj ^ s.c1[uei_pkg::C1_ODD];
              n.rs = uei_pkg::RX_STOP1;
            end
            uei_pkg::RX_STOP1: begin
              n.fe = ~maj;
              if (s.c1[uei_pkg::C1_STOP2]) begin
                n.rs = uei_pkg::RX_STOP2;
              end else begin
                n.rs = uei_pkg::RX_IDLE;
                push = 1'b1;
              end
            end
            uei_pkg::RX_STOP2: begin
              n.fe = s.fe | ~maj;
              n.rs = uei_pkg::RX_IDLE;
              push = 1'b1;
            end
            default: begin
              n.rs = uei_pkg::RX_IDLE;
            end
          endcase
        end
      end
    end
    // Completed word enters the queue or overruns
    if (push) begin
      if (n.cnt == 2'h2) begin
        n.f_oe = 1'b1;
        ev = s.c2[uei_pkg::C2_RXIRQ];
      end else begin
        n.fd[n.hd ^ n.cnt[0]] = s.shf;
        n.cnt = n.cnt + 2'h1;
        n.f_nf = n.f_nf | n.nz;
        n.f_fe = n.f_fe | n.fe;
        n.f_pe = n.f_pe | (n.pe & s.c1[uei_pkg::C1_PAR]);
        if (s.c2[uei_pkg::C2_RXIRQ] && (!s.c2[uei_pkg::C2_ADDR] || top)) begin
          ev = 1'b1;
        end
        if (s.c2[uei_pkg::C2_ADDR] && top) begin
          ev = 1'b1;
        end
      end
    end
    // Transmitter sources with their own enables
    if (sys_i.tx_empty && !s.txe_prev && s.c2[uei_pkg::C2_TEIE]) begin
      ev = 1'b1;
    end
    if (sys_i.tx_idle && !s.txi_prev && s.c2[uei_pkg::C2_TIIE]) begin
      ev = 1'b1;
    end
    // Wake arming on power-down entry, registers otherwise untouched
    if (pd_in && !s.pd_prev) begin
      n.armed = s.c2[uei_pkg::C2_WAKE] & s.c1[uei_pkg::C1_PORT]
              & s.c2[uei_pkg::C2_RXON] & s.c2[uei_pkg::C2_RXIRQ];
    end else if (!pd_in) begin
      n.armed = 1'b0;
    end
    if (pd_in && s.armed && fall) begin
      n.armed = 1'b0;
      n.wake = 1'b1;
      n.rec = 8'(RECOV);
      n.wake_irq = s.ic[uei_pkg::IC_GIE] & s.ic[uei_pkg::IC_UIE];
    end else if (s.rec != 8'h00) begin
      n.rec = s.rec - 8'h01;
      if (s.rec == 8'h01) begin
        ev = ev | s.wake_irq;
        n.wake_irq = 1'b0;
      end
    end
    // One request line, low pulse, pending until acknowledged
    if (ev) begin
      n.irq_n = 1'b0;
    end
    n.req = ev | (s.req & ~sys_i.irq_ack);
    n.serv = n.req & s.ic[uei_pkg::IC_GIE] & s.ic[uei_pkg::IC_UIE]
           & ~sys_i.stack_full;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.rs <= uei_pkg::RX_IDLE;
      s.c1 <= uei_pkg::CTRL1_RST;
      s.c2 <= uei_pkg::CTRL2_RST;
      s.baud <= uei_pkg::BAUD_RST;
      s.ic <= uei_pkg::INTC_RST;
      s.rx_prev <= 1'b1;
      s.irq_n <= 1'b1;
    end else begin
      s <= n;
    end
  end
endmodule
`default_nettype wire

// [common/uei_pkg.sv]
// Package for the serial receive error, interrupt and wake-up block
package uei_pkg;
  // Register byte offsets
  localparam logic [4:0] OFS_STATUS = 5'h00;
  localparam logic [4:0] OFS_CTRL1 = 5'h04;
  localparam logic [4:0] OFS_CTRL2 = 5'h08;
  localparam logic [4:0] OFS_DATA = 5'h0c;
  localparam logic [4:0] OFS_BAUD = 5'h10;
  localparam logic [4:0] OFS_INTC = 5'h14;
  // Status bits
  localparam int ST_PARITY = 0;
  localparam int ST_FRAME = 1;
  localparam int ST_NOISE = 2;
  localparam int ST_OVERRUN = 3;
  localparam int ST_RIDLE = 4;
  localparam int ST_RXF = 5;
  localparam int ST_TIDLE = 6;
  localparam int ST_TXE = 7;
  // Control one bits
  localparam int C1_RX9 = 0;
  localparam int C1_STOP2 = 3;
  localparam int C1_ODD = 4;
  localparam int C1_PAR = 5;
  localparam int C1_NINE = 6;
  localparam int C1_PORT = 7;
  // Control two bits
  localparam int C2_RXIRQ = 2;
  localparam int C2_WAKE = 3;
  localparam int C2_ADDR = 4;
  localparam int C2_RXON = 5;
  localparam int C2_TIIE = 6;
  localparam int C2_TEIE = 7;
  // Interrupt enable bits
  localparam int IC_GIE = 0;
  localparam int IC_UIE = 1;
  // Reset values
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [1:0] INTC_RST = 2'h0;
  // Timing
  localparam int CLK_NS = 8;
  localparam int RECOV_NS = 1000;
  localparam int RECOV_CYC = (RECOV_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] SMP_A = 4'h7;
  localparam logic [3:0] SMP_B = 4'h8;
  localparam logic [3:0] SMP_C = 4'h9;
  localparam logic [3:0] SMP_END = 4'hf;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PAR = 3'b011,
    RX_STOP1 = 3'b100,
    RX_STOP2 = 3'b101
  } uei_rx_type;

  typedef struct packed {
    logic tx_empty;
    logic tx_idle;
    logic stack_full;
    logic irq_ack;
  } uei_sys_in_type;

  typedef struct packed {
    uei_rx_type rs;
    logic [7:0] bcnt;
    logic [3:0] ovs;
    logic [3:0] bitn;
    logic [8:0] shf;
    logic [2:0] smp;
    logic nz;
    logic pe;
    logic fe;
    logic [1:0][8:0] fd;
    logic hd;
    logic [1:0] cnt;
    logic f_nf;
    logic f_fe;
    logic f_pe;
    logic f_oe;
    logic [7:0] c1;
    logic [7:0] c2;
    logic [7:0] baud;
    logic [1:0] ic;
    logic ack;
    logic [7:0] rdat;
    logic pop_ok;
    logic seen;
    logic rx_prev;
    logic txe_prev;
    logic txi_prev;
    logic pd_prev;
    logic armed;
    logic [7:0] rec;
    logic wake_irq;
    logic wake;
    logic irq_n;
    logic req;
    logic serv;
  } uei_state_type;
endpackage

// [tb/uei_rx_irq_monitor.sv]
// Checker for the serial receive interrupt block
`timescale 1ns/1ps
`default_nettype none
module uei_rx_irq_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Power and system
  input wire logic serial_port_clock_on,
  input wire logic power_down,
  input wire uei_pkg::uei_sys_in_type sys_i,
  input wire logic wake_req,
  input wire logic uart_irq_n,
  input wire logic uart_req,
  input wire logic irq_service
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_bus_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_bus_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
  a_irq_pulse_low: assert property (!uart_irq_n |=> uart_irq_n)
    else $error("irq pulse long");
  a_req_with_pulse: assert property (!uart_irq_n |-> uart_req)
    else $error("request flag missing");
  a_req_holds: assert property (uart_req && !sys_i.irq_ack |=> uart_req)
    else $error("request flag lost");
  a_service_cause: assert property (irq_service |-> uart_req && !$past(sys_i.stack_full))
    else $error("service without cause");
  a_full_blocks: assert property (uart_req && sys_i.stack_full |=> !irq_service)
    else $error("service with stack full");
  a_wake_pulse: assert property (wake_req |=> !wake_req)
    else $error("wake pulse long");
  a_wake_cause: assert property (wake_req |-> $past(power_down && !serial_port_clock_on))
    else $error("wake while running");
  a_wake_irq_late: assert property (wake_req |=> uart_irq_n [*3])
    else $error("wake irq early");
endmodule
bind uei_rx_irq uei_rx_irq_monitor u_mon (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .serial_port_clock_on(serial_port_clock_on),
  .power_down(power_down), .sys_i(sys_i), .wake_req(wake_req), .uart_irq_n(uart_irq_n),
  .uart_req(uart_req), .irq_service(irq_service));
`default_nettype wire

// [tb/uei_tx_model.sv]
// Remote serial transmitter model
`timescale 1ns/1ps
`default_nettype none
module uei_tx_model (
  // Clock
  input wire logic clk,
  // Line, idle high
  output logic rx
);
  initial rx = 1'b1;
  // Bits LSB first, 16 clocks each, optional one-clock glitch
  task automatic send(input logic [12:0] f, input int n, input logic gl);
    int i;
    int t;
    for (i = 0; i < n; i++) begin
      for (t = 0; t < 16; t++) begin
        @(posedge clk);
        rx <= f[i] ^ (gl && i == 1 && t == 8);
      end
    end
    @(posedge clk);
    rx <= 1'b1;
  endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Testbench for the serial receive interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst, cyc, stb, we, ack, rx, clk_on, pdn, wake, irq_n, req, serv;
  logic [4:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [7:0] q;
  uei_pkg::uei_sys_in_type sys;
  int mismatches, num_checks, irq_cnt, wake_cnt, i0, w0, j;
  uei_rx_irq #(.RECOV(4)) u_uei_rx_irq (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .rx(rx), .serial_port_clock_on(clk_on), .power_down(pdn), .sys_i(sys),
    .wake_req(wake), .uart_irq_n(irq_n), .uart_req(req), .irq_service(serv));
  uei_tx_model u_uei_tx_model (.clk(clk), .rx(rx));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rst === 1'b0 && irq_n === 1'b0) irq_cnt++;
    if (rst === 1'b0 && wake === 1'b1) wake_cnt++;
  end
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= a;
    wdat <= {24'h0, d};
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k == 20) begin
      mismatches++;
      results();
    end
  endtask
  task automatic rdc(input string n, input logic [4:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(n, e, q & ((a == uei_pkg::OFS_STATUS) ? 8'h2f : 8'hff));
  endtask
  task automatic settle;
    repeat (24) @(posedge clk);
    sys.irq_ack <= 1'b1;
    @(posedge clk);
    sys.irq_ack <= 1'b0;
  endtask
  task automatic cnt(input int ei, input int ew);
    chk("irq count", 8'(ei), 8'(irq_cnt - i0));
    chk("wake count", 8'(ew), 8'(wake_cnt - w0));
    i0 = irq_cnt;
    w0 = wake_cnt;
  endtask
  initial begin
    {rst, clk_on, cyc, stb, we, pdn, adr, wdat, sel} = {2'b11, 45'h0};
    sys = '0;
    {mismatches, num_checks, irq_cnt, wake_cnt} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wb(1'b1, uei_pkg::OFS_CTRL1, 8'h80);
    wb(1'b1, uei_pkg::OFS_CTRL2, 8'h24);
    wb(1'b1, uei_pkg::OFS_INTC, 8'h03);
    {i0, w0} = {irq_cnt, wake_cnt};
    u_uei_tx_model.send({4'hf, 8'ha5, 1'b0}, 10, 1'b1);
    settle();
    cnt(1, 0);
    rdc("status", uei_pkg::OFS_STATUS, 8'h24);
    wb(1'b1, uei_pkg::OFS_STATUS, 8'h00);
    rdc("status", uei_pkg::OFS_STATUS, 8'h24);
    rdc("data", uei_pkg::OFS_DATA, 8'ha5);
    rdc("status", uei_pkg::OFS_STATUS, 8'h00);
    wb(1'b1, uei_pkg::OFS_CTRL1, 8'h88);
    u_uei_tx_model.send({3'b110, 1'b1, 8'h3c, 1'b0}, 11, 1'b0);
    settle();
    cnt(1, 0);
    rdc("status", uei_pkg::OFS_STATUS, 8'h22);
    rdc("data", uei_pkg::OFS_DATA, 8'h3c);
    for (j = 0; j < 2; j++) begin
      wb(1'b1, uei_pkg::OFS_CTRL1, j ? 8'hb0 : 8'ha0);
      u_uei_tx_model.send({3'b111, 1'b0, 8'h01, 1'b0}, 11, 1'b0);
      settle();
      rdc("status", uei_pkg::OFS_STATUS, j ? 8'h20 : 8'h21);
      rdc("data", uei_pkg::OFS_DATA, 8'h01);
    end
    wb(1'b1, uei_pkg::OFS_CTRL1, 8'h80);
    cnt(2, 0);
    for (j = 0; j < 3; j++) u_uei_tx_model.send({4'hf, 8'(8'h10 + j), 1'b0}, 10, 1'b0);
    settle();
    cnt(3, 0);
    rdc("status", uei_pkg::OFS_STATUS, 8'h28);
    rdc("data", uei_pkg::OFS_DATA, 8'h10);
    rdc("data", uei_pkg::OFS_DATA, 8'h11);
    rdc("status", uei_pkg::OFS_STATUS, 8'h00);
    wb(1'b1, uei_pkg::OFS_CTRL2, 8'h34);
    for (j = 0; j < 2; j++) begin
      u_uei_tx_model.send({4'hf, j ? 8'h85 : 8'h05, 1'b0}, 10, 1'b0);
      settle();
      cnt(j, 0);
    end
    rdc("status", uei_pkg::OFS_STATUS, 8'h20);
    rdc("data", uei_pkg::OFS_DATA, 8'h05);
    rdc("data", uei_pkg::OFS_DATA, 8'h85);
    // Nine-bit address word with the receive interrupt enable off
    wb(1'b1, uei_pkg::OFS_CTRL1, 8'hc0);
    wb(1'b1, uei_pkg::OFS_CTRL2, 8'h30);
    u_uei_tx_model.send({3'b111, 9'h1a5, 1'b0}, 11, 1'b0);
    settle();
    cnt(1, 0);
    rdc("ninth bit", uei_pkg::OFS_CTRL1, 8'hc1);
    rdc("status", uei_pkg::OFS_STATUS, 8'h20);
    rdc("data", uei_pkg::OFS_DATA, 8'ha5);
    wb(1'b1, uei_pkg::OFS_CTRL1, 8'h80);
    for (j = 0; j < 4; j++) begin
      wb(1'b1, uei_pkg::OFS_CTRL2, (j[0] ^ j[1]) ? 8'h80 : 8'h40);
      sys.stack_full <= (j == 1);
      if (j[0]) sys.tx_empty <= 1'b1;
      else sys.tx_idle <= 1'b1;
      repeat (3) @(posedge clk);
      chk("request", 8'(!j[1]), {7'h00, req});
      chk("service", 8'(j == 0), {7'h00, serv});
      settle();
      {sys.tx_empty, sys.tx_idle, sys.stack_full} <= 3'h0;
      cnt(!j[1], 0);
    end
    for (j = 0; j < 3; j++) begin
      wb(1'b1, uei_pkg::OFS_CTRL2, (j == 2) ? 8'h24 : 8'h2c);
      wb(1'b1, uei_pkg::OFS_INTC, (j == 1) ? 8'h00 : 8'h03);
      {clk_on, pdn} <= 2'b01;
      u_uei_tx_model.send(13'h1ffe, 1, 1'b0);
      settle();
      {clk_on, pdn} <= 2'b10;
      cnt(j == 0, j < 2);
      rdc("status", uei_pkg::OFS_STATUS, 8'h00);
    end
    rdc("ctrl1", uei_pkg::OFS_CTRL1, 8'h80);
    rdc("unmapped", 5'h1c, 8'h00);
    // Framing error, then a reset in mid-run clears it
    u_uei_tx_model.send({4'he, 8'h3c, 1'b0}, 10, 1'b0);
    settle();
    cnt(1, 0);
    rdc("status", uei_pkg::OFS_STATUS, 8'h22);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc("status", uei_pkg::OFS_STATUS, 8'h00);
    rdc("ctrl1", uei_pkg::OFS_CTRL1, 8'h00);
    results();
  end
endmodule
`default_nettype wire
